// ### inc/csx_regs.vh
// Constants for the compare-and-skip execution block
`ifndef CSX_REGS_VH
`define CSX_REGS_VH
`define CSX_OP_HI_W        7
`define CSX_OP_GT          7'h32
`define CSX_OP_EQ          7'h31
`define CSX_BANK_BIT       8
`define CSX_ILO_LIMIT      8'h5f
`define CSX_QPH_RESET      2'h0
`define CSX_QPH_LAST       2'h3
`define CSX_IDLE_RESET     2'h0
`define CSX_QPH_DECODE     2'h0
`define CSX_QPH_READ       2'h1
`define CSX_QPH_CMP        2'h2
`define CSX_WORDS_TWO      2'h2
`define CSX_WORDS_THREE    2'h3
`define CSX_IDLE_ONE       2'h1
`define CSX_IDLE_TWO       2'h2
`define CSX_IDLE_THREE     2'h3
`define CSX_ACCESS_SPLIT   8'h60
`define CSX_ACCESS_HI_BANK 6'h3f
`endif

// ### logic/csx_qphase.v
// Quarter-phase sequencer: splits the clock into four phases per instruction cycle
`timescale 1ns/1ns
`include "csx_regs.vh"
module csx_qphase
(
	input  wire       i_mclk,
	input  wire       i_rst_n,
	output wire [1:0] o_qph,
	output wire       o_cyc_end
);
	reg [1:0] qph_q;

	// Free-running phase count, one enable pulse per instruction cycle
	always @(posedge i_mclk)
	begin
		if (!i_rst_n)
			qph_q <= `CSX_QPH_RESET;
		else
			qph_q <= qph_q + 2'h1;
	end

	assign o_qph     = qph_q;
	assign o_cyc_end = (qph_q == `CSX_QPH_LAST);
endmodule // csx_qphase

// ### logic/csx_exec.v
// Execution of compare-file-with-working-register-and-skip instructions
`timescale 1ns/1ns
`include "csx_regs.vh"
module csx_exec
(
	input  wire        i_mclk,
	input  wire        i_rst_n,
	input  wire [15:0] i_opcode,
	input  wire        i_op_valid,
	input  wire        i_ext_set_en,
	input  wire [5:0]  i_bank_select_register,
	input  wire [11:0] i_fsr2,
	input  wire [7:0]  i_file_rdata,
	input  wire [7:0]  i_working_register,
	input  wire [1:0]  i_next_words,
	output reg  [11:0] o_file_addr,
	output reg         o_file_rd,
	output reg         o_flush,
	output reg         o_no_operation,
	output reg         o_pc_skip,
	output reg         o_busy,
	output reg         o_cmp_done
);
	// One instruction cycle is four clocks, one per quarter phase:
	//   phase 0  opcode taken, address and read strobe launched
	//   phase 1  file operand captured
	//   phase 2  compare result frozen into take_q, done strobe launched
	//   phase 3  nothing written back; a true compare flushes at its end
	// Freezing the result at phase 2 lets the working register move
	// afterwards without changing the decision. Outputs are registered
	// from the next state, so o_busy rises at the decode edge itself.
	// Instruction states
	localparam ST_IDLE = 2'h0;
	localparam ST_EXEC = 2'h1;
	localparam ST_SKIP = 2'h2;

	wire [1:0] qph;
	wire       cyc_end;
	reg  [1:0] st_q;
	reg  [1:0] st_d;
	reg        is_gt_q;
	reg        is_eq_q;
	reg  [7:0] fdata_q;
	reg        take_q;
	reg  [1:0] idle_q;
	reg  [8:0] diff;
	reg        hit;
	reg        gt_hit;
	reg        eq_hit;

	// Quarter-phase divider; cyc_end is the one-clock enable per cycle
	csx_qphase u_qphase
	(
		.i_mclk    (i_mclk),
		.i_rst_n   (i_rst_n),
		.o_qph     (qph),
		.o_cyc_end (cyc_end)
	);

	// Opcode class tests, shared by the sequencer and the variant latch
	function op_is_gt;
		input [6:0] hi;
		begin
			op_is_gt = (hi == `CSX_OP_GT);
		end
	endfunction

	function op_is_eq;
		input [6:0] hi;
		begin
			op_is_eq = (hi == `CSX_OP_EQ);
		end
	endfunction

	// A 256-byte bank placed by its number; the 12-bit address keeps only
	// the low four bank bits, so higher bank numbers alias onto lower ones
	function [11:0] bank_addr;
		input [5:0] bank;
		input [7:0] f;
		begin
			bank_addr = {bank[3:0], f};
		end
	endfunction

	// Idle instruction cycles after a true compare, by follower length;
	// a length code of zero is read as one word rather than refused
	function [1:0] idle_cycles;
		input [1:0] words;
		begin
			if (words == `CSX_WORDS_THREE)
				idle_cycles = `CSX_IDLE_THREE;
			else if (words == `CSX_WORDS_TWO)
				idle_cycles = `CSX_IDLE_TWO;
			else
				idle_cycles = `CSX_IDLE_ONE;
		end
	endfunction

	// Operand address resolution, shared by both variants
	function [11:0] resolve_addr;
		input [7:0]  f;
		input        a;
		input        ext;
		input [5:0]  bank_select_register;
		input [11:0] base;
		begin
			if (a)
				resolve_addr = bank_addr(bank_select_register, f);
			else if (ext && (f <= `CSX_ILO_LIMIT))
				resolve_addr = base + {4'h0, f};
			else if (f < `CSX_ACCESS_SPLIT)
				resolve_addr = {4'h0, f};
			else
				resolve_addr = bank_addr(`CSX_ACCESS_HI_BANK, f);
		end
	endfunction

	// Compare: 9-bit subtract keeps the borrow; nothing is ever written back
	always @*
	begin
		diff = {1'b0, fdata_q} - {1'b0, i_working_register};
		// A borrow into bit 8 marks a file operand below the working register
		gt_hit = is_gt_q && !diff[8] && (diff[7:0] != 8'h00);
		eq_hit = is_eq_q && (diff[7:0] == 8'h00);
		hit    = gt_hit || eq_hit;
	end

	// State sequencing across instruction cycles
	always @*
	begin
		st_d = st_q;
		case (st_q)
			ST_IDLE:
				// Off-phase or unknown opcodes fall through untouched
				if (i_op_valid && qph == `CSX_QPH_DECODE
					&& (op_is_gt(i_opcode[15:9]) || op_is_eq(i_opcode[15:9])))
					st_d = ST_EXEC;
			ST_EXEC:
				if (cyc_end)
					st_d = take_q ? ST_SKIP : ST_IDLE;
			ST_SKIP:
				// Leave at the end of the last idle instruction cycle
				if (cyc_end && idle_q == `CSX_IDLE_ONE)
					st_d = ST_IDLE;
			default:
				st_d = ST_IDLE;
		endcase
	end

	// Datapath registers, stepped by quarter phase
	always @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			st_q           <= ST_IDLE;
			is_gt_q        <= 1'b0;
			is_eq_q        <= 1'b0;
			fdata_q        <= 8'h00;
			take_q         <= 1'b0;
			idle_q         <= `CSX_IDLE_RESET;
			o_file_addr    <= 12'h000;
			o_file_rd      <= 1'b0;
			o_flush        <= 1'b0;
			o_no_operation <= 1'b0;
			o_pc_skip      <= 1'b0;
			o_busy         <= 1'b0;
			o_cmp_done     <= 1'b0;
		end
		else
		begin
			st_q       <= st_d;
			// Strobes default low so each is a single-clock pulse
			o_file_rd  <= 1'b0;
			o_flush    <= 1'b0;
			o_pc_skip  <= 1'b0;
			o_cmp_done <= 1'b0;
			o_busy     <= (st_d != ST_IDLE);
			o_no_operation <= (st_d == ST_SKIP);
			// Q1 decode latches variant and drives the address
			if (st_q == ST_IDLE && st_d == ST_EXEC)
			begin
				is_gt_q     <= op_is_gt(i_opcode[15:9]);
				is_eq_q     <= op_is_eq(i_opcode[15:9]);
				o_file_addr <= resolve_addr(i_opcode[7:0], i_opcode[`CSX_BANK_BIT],
					i_ext_set_en, i_bank_select_register, i_fsr2);
				o_file_rd   <= 1'b1;
			end
			// Q2 read of the file operand
			if (st_q == ST_EXEC && qph == `CSX_QPH_READ)
				fdata_q <= i_file_rdata;
			// Q3 compare; Q4 writes nothing
			if (st_q == ST_EXEC && qph == `CSX_QPH_CMP)
			begin
				take_q     <= hit;
				o_cmp_done <= 1'b1;
			end
			// Idle cycles count taken from the prefetched word's length
			// The decision is the one frozen at phase 2, not a fresh compare
			if (st_q == ST_EXEC && cyc_end && take_q)
			begin
				o_flush   <= 1'b1;
				o_pc_skip <= 1'b1;
				idle_q    <= idle_cycles(i_next_words);
			end
			// One idle instruction cycle used up
			else if (st_q == ST_SKIP && cyc_end)
				idle_q <= idle_q - 2'h1;
		end
	end
endmodule // csx_exec

// ### sim/csx_exec_properties.sv
// Port-level timing checks for the compare-and-skip block
`timescale 1ns/1ns
module csx_exec_chk
(
	input logic i_mclk,
	input logic i_rst_n,
	input logic [1:0] i_next_words,
	input logic o_file_rd,
	input logic o_flush,
	input logic o_no_operation,
	input logic o_pc_skip,
	input logic o_busy,
	input logic o_cmp_done
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	// One idle instruction cycle is four quarter-phases
	sequence s_idle_cyc;
		o_no_operation [*4];
	endsequence
	// Two and three idle instruction cycles, then the strobe drops
	sequence s_idle_two;
		s_idle_cyc ##1 s_idle_cyc ##1 !o_no_operation;
	endsequence
	sequence s_idle_three;
		s_idle_cyc ##1 s_idle_cyc ##1 s_idle_cyc ##1 !o_no_operation;
	endsequence
	// Idle length follows the follower length seen at the flush edge
	AST_NOP_TWO: assert property (
		o_flush && $past(i_next_words) == 2'h2 |-> s_idle_two) else $error("two idle");
	AST_NOP_THREE: assert property (
		o_flush && $past(i_next_words) == 2'h3 |-> s_idle_three) else $error("three idle");
	// Read, compare and skip strobes in their fixed order
	AST_RD_START: assert property ($rose(o_busy) |-> o_file_rd) else $error("rd");
	AST_DONE: assert property (o_file_rd |-> ##[1:3] o_cmp_done) else $error("done");
	AST_DONE_BUSY: assert property (o_cmp_done |-> o_busy) else $error("dbusy");
	AST_PAIR: assert property (o_flush |-> o_pc_skip) else $error("pair");
	AST_FPULSE: assert property (o_flush |=> !o_flush) else $error("pulse");
	AST_NOP_START: assert property ($rose(o_no_operation) |-> o_flush) else $error("st");
	AST_NOP_LEN: assert property ($rose(o_no_operation) |-> s_idle_cyc) else $error("len");
	AST_NOP_BUSY: assert property (o_no_operation |-> o_busy) else $error("nb");
endmodule // csx_exec_chk
bind csx_exec csx_exec_chk i_chk
(
	.i_mclk         (i_mclk),
	.i_rst_n        (i_rst_n),
	.i_next_words   (i_next_words),
	.o_file_rd      (o_file_rd),
	.o_flush        (o_flush),
	.o_no_operation (o_no_operation),
	.o_pc_skip      (o_pc_skip),
	.o_busy         (o_busy),
	.o_cmp_done     (o_cmp_done)
);

// ### sim/tb.sv
// Bench for the compare-and-skip block
`timescale 1ns/1ns
module tb;
	logic i_mclk = 0, i_rst_n = 0, i_op_valid = 0, i_ext_set_en = 0;
	logic [15:0] i_opcode = 16'h0000;
	logic [5:0] i_bank_select_register = 6'h0a;
	logic [11:0] i_fsr2 = 12'h100, o_file_addr;
	logic [7:0] i_file_rdata = 8'h00, i_working_register = 8'h00;
	logic [1:0] i_next_words = 2'h1;
	logic o_file_rd, o_flush, o_no_operation, o_pc_skip, o_busy, o_cmp_done;
	int fail_count = 0, n_checks = 0, cyc = 0;
	csx_exec i_dut
	(
		.i_mclk                 (i_mclk),
		.i_rst_n                (i_rst_n),
		.i_opcode               (i_opcode),
		.i_op_valid             (i_op_valid),
		.i_ext_set_en           (i_ext_set_en),
		.i_bank_select_register (i_bank_select_register),
		.i_fsr2                 (i_fsr2),
		.i_file_rdata           (i_file_rdata),
		.i_working_register     (i_working_register),
		.i_next_words           (i_next_words),
		.o_file_addr            (o_file_addr),
		.o_file_rd              (o_file_rd),
		.o_flush                (o_flush),
		.o_no_operation         (o_no_operation),
		.o_pc_skip              (o_pc_skip),
		.o_busy                 (o_busy),
		.o_cmp_done             (o_cmp_done)
	);
	// Clock, and a cycle ceiling so a stuck block cannot hang the run
	initial forever #5 i_mclk = ~i_mclk;
	always @(posedge i_mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			fail_count++;
			wrap_up;
		end
	end
	task automatic chk(input string nm, input logic [11:0] s, e);
		n_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("wrong value %s exp %h got %h", nm, e, s);
		end
	endtask
	// Offer one opcode until taken, then tally skip strobe and idle cycles
	task automatic go(input [15:0] op, input [7:0] fd, w, input [1:0] nw,
		input [11:0] ea, input sk);
		logic [11:0] n, ad, fl, rd, cd, bc, ei;
		logic s, tk;
		int k;
		n = 0;
		fl = 0;
		rd = 0;
		cd = 0;
		bc = 0;
		s = 0;
		k = 0;
		ei = sk ? 12'(4 * (nw > 1 ? nw : 1)) : 12'h000;
		@(negedge i_mclk);
		{i_opcode, i_file_rdata, i_working_register, i_next_words} = {op, fd, w, nw};
		i_op_valid = 1;
		while (!o_busy && k < 20)
		begin
			@(negedge i_mclk);
			k++;
		end
		tk = o_busy;
		ad = o_file_addr;
		i_op_valid = 0;
		while (o_busy && k < 60)
		begin
			s |= o_pc_skip;
			n += o_no_operation;
			fl += o_flush;
			rd += o_file_rd;
			cd += o_cmp_done;
			bc += 1;
			@(negedge i_mclk);
			k++;
		end
		chk("taken", {11'h000, tk}, 12'h001);
		chk("addr", ad, ea);
		chk("skip", {11'h000, s}, {11'h000, sk});
		chk("flush", fl, {11'h000, sk});
		chk("idle", n, ei);
		// Busy rises at the decode edge, after the phase 0 clock, so the first cycle shows three
		chk("busy", bc, ei + 12'h003);
		chk("read", rd, 12'h001);
		chk("cmp", cd, 12'h001);
	endtask
	// Greater-than: equal boundary, unsigned extremes, every follower length
	task t_gt;
		go(16'h6470, 8'h81, 8'h80, 2'h1, 12'hf70, 1);
		go(16'h6470, 8'h80, 8'h80, 2'h1, 12'hf70, 0);
		go(16'h6470, 8'h00, 8'hff, 2'h3, 12'hf70, 0);
		go(16'h6470, 8'hff, 8'h00, 2'h2, 12'hf70, 1);
		go(16'h6470, 8'hff, 8'h7f, 2'h3, 12'hf70, 1);
	endtask
	// Equality variant, with a zero length read as one word
	task t_eq;
		go(16'h6270, 8'h55, 8'h55, 2'h0, 12'hf70, 1);
		go(16'h6270, 8'h56, 8'h55, 2'h3, 12'hf70, 0);
	endtask
	// Less-than and an unused pattern, held across phase 0: never taken
	task automatic t_refuse;
		int k;
		logic b;
		b = 0;
		@(negedge i_mclk);
		{i_opcode, i_file_rdata, i_working_register} = {16'h6070, 8'h81, 8'h80};
		i_op_valid = 1;
		for (k = 0; k < 12; k++)
		begin
			@(negedge i_mclk);
			b |= o_busy;
			if (k == 5)
				i_opcode = 16'h6670;
		end
		i_op_valid = 0;
		chk("refuse", {11'h000, b}, 12'h000);
	endtask
	// Operand address in banked, access and indexed modes
	task t_addr;
		go(16'h6512, 8'h01, 8'h00, 2'h1, 12'ha12, 1);
		go(16'h645f, 8'h01, 8'h00, 2'h1, 12'h05f, 1);
		i_ext_set_en = 1;
		go(16'h645f, 8'h01, 8'h00, 2'h1, 12'h15f, 1);
		go(16'h6460, 8'h01, 8'h00, 2'h1, 12'hf60, 1);
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Reset for ten cycles, then the scenarios
	initial
	begin
		repeat (10) @(negedge i_mclk);
		i_rst_n = 1;
		t_gt;
		t_eq;
		t_refuse;
		t_addr;
		wrap_up;
	end
endmodule // tb
